// ==== design/tmc_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the timer modules
`ifndef TMC_CFG_SVH
`define TMC_CFG_SVH
// Register indices on the plain register port
`define TMC_ADDR_W 4
`define TMC_REG_CTRL0_A 4'h0
`define TMC_REG_CTRL1_A 4'h1
`define TMC_REG_CMPA_A 4'h2
`define TMC_REG_CNT_A 4'h3
`define TMC_REG_CTRL0_B 4'h4
`define TMC_REG_CTRL1_B 4'h5
`define TMC_REG_CMPA_B 4'h6
`define TMC_REG_CNT_B 4'h7
`define TMC_REG_CTRL0_S 4'h8
`define TMC_REG_CTRL1_S 4'h9
`define TMC_REG_CMPA_S 4'hA
`define TMC_REG_CNT_S 4'hB
`define TMC_REG_PINCTL 4'hC
`define TMC_REG_LATCH 4'hD
`define TMC_REG_STATUS 4'hE
// Control-zero field positions
`define TMC_C0_PAUSE 7
`define TMC_C0_CK_HI 6
`define TMC_C0_CK_LO 4
`define TMC_C0_RUN 3
`define TMC_C0_RP_HI 2
`define TMC_C0_RP_LO 0
// Control-one field positions
`define TMC_C1_MODE_HI 7
`define TMC_C1_MODE_LO 6
`define TMC_C1_IO_HI 5
`define TMC_C1_IO_LO 4
`define TMC_C1_INIT 3
`define TMC_C1_POL 2
`define TMC_C1_CCLR 0
// Reset values
`define TMC_PINCTL_RST 8'h05
`define TMC_LATCH_RST 8'h00
// Clock dividers
`define TMC_DIV_SYS4 4
`define TMC_DIV_H16 16
`define TMC_DIV_H64 64
`define TMC_TBC_DIV 256
`endif

// ==== design/tmc_pkg.sv ====
// Types shared by the timer module framework
`default_nettype none
package tmc_pkg;
   typedef enum logic [2:0] {
      TMC_CK_SYS4 = 3'b000,
      TMC_CK_SYS = 3'b001,
      TMC_CK_H16 = 3'b010,
      TMC_CK_H64 = 3'b011,
      TMC_CK_TBC = 3'b100,
      TMC_CK_NONE = 3'b101,
      TMC_CK_EXT_RISE = 3'b110,
      TMC_CK_EXT_FALL = 3'b111
   } tmc_clksel_e;
   typedef enum logic [1:0] {
      TMC_M_CMP = 2'b00,
      TMC_M_PWM = 2'b10,
      TMC_M_TIMER = 2'b11,
      TMC_M_PULSE = 2'b01
   } tmc_mode_e;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tmc_bus_s;
   typedef struct packed {
      logic pause;
      logic [2:0] clk_sel;
      logic run;
      logic [2:0] period;
   } tmc_ctrl0_s;
   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] io;
      logic init;
      logic pol;
      logic dpx;
      logic cclr;
   } tmc_ctrl1_s;
endpackage : tmc_pkg
`default_nettype wire

// ==== design/tmc_timers.sv ====
// Two compact timers and one standard timer with shared clock selection and pin control
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module tmc_timers
   import tmc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // External timer inputs, one per timer
   input wire logic [2:0] ext_timer_input,
   // Interrupt events, one-cycle pulses, per timer
   output logic [2:0] irq_cmp_a,
   output logic [2:0] irq_cmp_p,
   // Output pins with enables; the enable is low while the timer drives
   output logic timer_a_out_primary,
   output logic timer_a_out_secondary,
   output logic timer_b_out_primary,
   output logic timer_b_out_secondary,
   output logic standard_out_primary,
   output logic [4:0] timer_pin_oe_n
);
   ////////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] ctrl0_reg [3];
   logic [7:0] ctrl1_reg [3];
   logic [15:0] cmpa_reg [3];
   logic [7:0] cmpa_lo_buf_reg;
   logic [7:0] cnt_lo_buf_reg;
   logic [4:0] pinctl_reg;
   logic [4:0] latch_reg;
   logic [15:0] cnt_reg [3];
   logic [2:0] ext_s1_reg, ext_s2_reg, ext_s3_reg;
   logic [2:0] run_d_reg;
   logic [5:0] div_reg;
   logic [7:0] tbc_reg;
   logic [1:0] tout_reg [3];
   logic [2:0] stat_a_reg, stat_p_reg;

   // Decode a register index into timer number and register kind
   function automatic logic [1:0] tmr_of(input logic [3:0] a);
      return a[3:2];
   endfunction : tmr_of
   function automatic logic [1:0] kind_of(input logic [3:0] a);
      return a[1:0];
   endfunction : kind_of

   // Prescaler: one-cycle enables for every divided internal rate
   logic en_sys4, en_h16, en_h64, en_tbc;
   always_ff @(posedge clk) begin
      if (reset) begin
         div_reg <= 6'h00;
         tbc_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 6'h01;
         tbc_reg <= tbc_reg + 8'h01;
      end
   end
   assign en_sys4 = (div_reg[1:0] == 2'(`TMC_DIV_SYS4 - 1));
   assign en_h16 = (div_reg[3:0] == 4'(`TMC_DIV_H16 - 1));
   assign en_h64 = (div_reg == 6'(`TMC_DIV_H64 - 1));
   assign en_tbc = (tbc_reg == 8'(`TMC_TBC_DIV - 1));

   // External inputs: two-flop synchroniser, third flop for edge detection
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_s1_reg <= 3'h0;
         ext_s2_reg <= 3'h0;
         ext_s3_reg <= 3'h0;
      end else begin
         ext_s1_reg <= ext_timer_input;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes; the low compare byte waits in a buffer until high is written
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < 3; i++) begin
            ctrl0_reg[i] <= 8'h00;
            ctrl1_reg[i] <= 8'h00;
            cmpa_reg[i] <= 16'h0000;
         end
         cmpa_lo_buf_reg <= 8'h00;
         pinctl_reg <= 5'(`TMC_PINCTL_RST);
         latch_reg <= 5'(`TMC_LATCH_RST);
      end else if (reg_wr) begin
         if (reg_addr == `TMC_REG_PINCTL) begin
            pinctl_reg <= reg_wdata[4:0];
         end else if (reg_addr == `TMC_REG_LATCH) begin
            latch_reg <= reg_wdata[4:0];
         end else if (tmr_of(reg_addr) != 2'h3) begin
            unique case (kind_of(reg_addr))
               2'h0: ctrl0_reg[tmr_of(reg_addr)] <= reg_wdata;
               2'h1: ctrl1_reg[tmr_of(reg_addr)] <= reg_wdata;
               2'h2: begin
                  // Even write is the low byte into the buffer, odd is high plus latch
                  cmpa_lo_buf_reg <= reg_wdata;
               end
               2'h3: begin
                  cmpa_reg[tmr_of(reg_addr)] <= {reg_wdata, cmpa_lo_buf_reg};
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-timer counters, comparators and outputs
   logic [2:0] tick, match_a, match_p, ovf;
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_tmr
         localparam int W = (g == 2) ? 16 : 10;
         tmc_ctrl0_s c0;
         tmc_ctrl1_s c1;
         logic [W-1:0] cnt;
         logic [W-1:0] cmp_p_full;
         logic clr_now;
         assign c0 = ctrl0_reg[g];
         assign c1 = ctrl1_reg[g];
         assign cnt = cnt_reg[g][W-1:0];
         // Period comparator value is the P code in the top three bits, lower bits zero; zero means full range
         assign cmp_p_full = {c0.period, {(W-3){1'b0}}};
         // Counter clock selection
         always_comb begin
            unique case (tmc_clksel_e'(c0.clk_sel))
               TMC_CK_SYS4: tick[g] = en_sys4;
               TMC_CK_SYS: tick[g] = 1'b1;
               TMC_CK_H16: tick[g] = en_h16;
               TMC_CK_H64: tick[g] = en_h64;
               TMC_CK_TBC: tick[g] = en_tbc;
               TMC_CK_NONE: tick[g] = 1'b0;
               TMC_CK_EXT_RISE: tick[g] = ext_s2_reg[g] & ~ext_s3_reg[g];
               TMC_CK_EXT_FALL: tick[g] = ~ext_s2_reg[g] & ext_s3_reg[g];
            endcase
         end
         // Compare evaluates the next count so match and clear share one tick
         logic [W-1:0] cnt_inc;
         logic cnt_go;
         // Counting starts the cycle after the run rise: a count left over from before
         // the stop must not raise a match on the clearing edge
         assign cnt_go = c0.run & run_d_reg[g] & ~c0.pause & tick[g];
         assign cnt_inc = cnt + W'(1);
         assign match_a[g] = cnt_go & (cnt_inc == cmpa_reg[g][W-1:0]);
         assign match_p[g] = cnt_go & (c0.period == 3'h0 ?
            (cnt_inc == {W{1'b0}}) : (cnt_inc == cmp_p_full));
         assign ovf[g] = cnt_go & (cnt == {W{1'b1}});
         // Clear on A match if chosen, else on P match; overflow always wraps to zero
         assign clr_now = (c1.cclr ? match_a[g] : match_p[g]) | ovf[g];
         always_ff @(posedge clk) begin
            if (reset) begin
               cnt_reg[g] <= 16'h0000;
               run_d_reg[g] <= 1'b0;
            end else begin
               run_d_reg[g] <= c0.run;
               if (c0.run & ~run_d_reg[g]) begin
                  cnt_reg[g] <= 16'h0000;
               end else if (cnt_go) begin
                  cnt_reg[g] <= clr_now ? 16'h0000 : 16'(cnt_inc);
               end
            end
         end
         // Output generation: compare-match actions, edge aligned PWM or single pulse
         always_ff @(posedge clk) begin
            if (reset) begin
               tout_reg[g] <= 2'b00;
            end else if (!c0.run) begin
               tout_reg[g][0] <= c1.init;
            end else if (tmc_mode_e'(c1.mode) == TMC_M_CMP && match_a[g]) begin
               unique case (c1.io)
                  2'b00: tout_reg[g][0] <= tout_reg[g][0];
                  2'b01: tout_reg[g][0] <= 1'b0;
                  2'b10: tout_reg[g][0] <= 1'b1;
                  2'b11: tout_reg[g][0] <= ~tout_reg[g][0];
               endcase
            end else if (tmc_mode_e'(c1.mode) == TMC_M_PWM && cnt_go) begin
               // Period fixed by P, duty by A: edge aligned at counter start
               if (match_p[g] | ovf[g]) begin
                  tout_reg[g][0] <= 1'b1;
               end else if (match_a[g]) begin
                  tout_reg[g][0] <= 1'b0;
               end
            end else if (g == 2 && tmc_mode_e'(c1.mode) == TMC_M_PULSE) begin
               // Single pulse: high from run start to A match, standard only
               tout_reg[g][0] <= ~(match_a[g] | (tout_reg[g][1] & ~tout_reg[g][0]));
            end
            if (!reset) begin
               tout_reg[g][1] <= run_d_reg[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt events and sticky status, cleared when read; set wins
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_cmp_a <= 3'h0;
         irq_cmp_p <= 3'h0;
         stat_a_reg <= 3'h0;
         stat_p_reg <= 3'h0;
      end else begin
         irq_cmp_a <= match_a;
         irq_cmp_p <= match_p;
         if (reg_rd && reg_addr == `TMC_REG_STATUS) begin
            stat_a_reg <= match_a;
            stat_p_reg <= match_p;
         end else begin
            stat_a_reg <= stat_a_reg | match_a;
            stat_p_reg <= stat_p_reg | match_p;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins: polarity, complementary pair from latch bits, pin enable
   logic [4:0] pin_val;
   always_comb begin
      pin_val[0] = tout_reg[0][0] ^ ctrl1_reg[0][`TMC_C1_POL] ^ latch_reg[0];
      pin_val[1] = tout_reg[0][0] ^ ctrl1_reg[0][`TMC_C1_POL] ^ latch_reg[1];
      pin_val[2] = tout_reg[1][0] ^ ctrl1_reg[1][`TMC_C1_POL] ^ latch_reg[2];
      pin_val[3] = tout_reg[1][0] ^ ctrl1_reg[1][`TMC_C1_POL] ^ latch_reg[3];
      pin_val[4] = tout_reg[2][0] ^ ctrl1_reg[2][`TMC_C1_POL] ^ latch_reg[4];
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         timer_a_out_primary <= 1'b0;
         timer_a_out_secondary <= 1'b0;
         timer_b_out_primary <= 1'b0;
         timer_b_out_secondary <= 1'b0;
         standard_out_primary <= 1'b0;
         timer_pin_oe_n <= 5'h1F;
      end else begin
         timer_a_out_primary <= pin_val[0] & pinctl_reg[0];
         timer_a_out_secondary <= pin_val[1] & pinctl_reg[1];
         timer_b_out_primary <= pin_val[2] & pinctl_reg[2];
         timer_b_out_secondary <= pin_val[3] & pinctl_reg[3];
         standard_out_primary <= pin_val[4] & pinctl_reg[4];
         timer_pin_oe_n <= ~pinctl_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path: high-byte read of counter latches low byte into a buffer
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         cnt_lo_buf_reg <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= 8'h00;
         if (reg_addr == `TMC_REG_PINCTL) begin
            reg_rdata <= {3'b000, pinctl_reg};
         end else if (reg_addr == `TMC_REG_LATCH) begin
            reg_rdata <= {3'b000, latch_reg};
         end else if (reg_addr == `TMC_REG_STATUS) begin
            reg_rdata <= {2'b00, stat_p_reg, stat_a_reg};
         end else if (tmr_of(reg_addr) != 2'h3) begin
            unique case (kind_of(reg_addr))
               2'h0: reg_rdata <= ctrl0_reg[tmr_of(reg_addr)];
               2'h1: reg_rdata <= ctrl1_reg[tmr_of(reg_addr)];
               2'h2: reg_rdata <= cnt_lo_buf_reg;
               2'h3: begin
                  reg_rdata <= cnt_reg[tmr_of(reg_addr)][15:8];
                  cnt_lo_buf_reg <= cnt_reg[tmr_of(reg_addr)][7:0];
               end
            endcase
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule : tmc_timers
`default_nettype wire

// ==== test/tmc_monitor.sv ====
// Port checker for the timer module framework
`timescale 1ns/100ps
`default_nettype none
module tmc_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Events and pins
   input wire logic [2:0] irq_cmp_a,
   input wire logic [2:0] irq_cmp_p,
   input wire logic timer_a_out_primary,
   input wire logic timer_a_out_secondary,
   input wire logic standard_out_primary,
   input wire logic [4:0] timer_pin_oe_n
);
   // A pin-control write followed by a quiet cycle, so the enables settle
   sequence pin_wr_s;
      reg_wr && reg_addr == 4'hC ##1 !(reg_wr && reg_addr == 4'hC);
   endsequence
   // Reset silences events and releases every pin
   AST_RESET_QUIET: assert property (@(posedge clk) reset |=>
      irq_cmp_a == 3'h0 && irq_cmp_p == 3'h0 && timer_pin_oe_n == 5'h1F)
      else $error("outputs active after reset");
   AST_ENABLE_DEFAULT: assert property (@(posedge clk)
      $fell(reset) |=> timer_pin_oe_n == 5'h1A) else $error("pin enables wrong after reset");
   // Read data stand one cycle only
   AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (reset)
      !reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read cycle");
   AST_PIN_READBACK: assert property (@(posedge clk) disable iff (reset)
      reg_rd && reg_addr == 4'hC |=> reg_rdata == {3'h0, ~timer_pin_oe_n})
      else $error("pin control readback differs from enables");
   AST_PIN_ROUTE: assert property (@(posedge clk) disable iff (reset)
      pin_wr_s |=> timer_pin_oe_n == ~$past(reg_wdata[4:0], 2))
      else $error("pin enables do not follow pin control");
   // A pin left on its other function carries no timer output
   AST_PIN_A0_OFF: assert property (@(posedge clk) disable iff (reset)
      timer_pin_oe_n[0] |-> !timer_a_out_primary) else $error("disabled pin driven");
   AST_PIN_A1_OFF: assert property (@(posedge clk) disable iff (reset)
      timer_pin_oe_n[1] |-> !timer_a_out_secondary) else $error("disabled pin driven");
   AST_PIN_S_OFF: assert property (@(posedge clk) disable iff (reset)
      $rose(standard_out_primary) |-> !timer_pin_oe_n[4]) else $error("disabled pin rose");
endmodule : tmc_monitor
`default_nettype wire

// ==== test/tmc_ext_src.sv ====
// Behavioural source for the external timer inputs
`timescale 1ns/100ps
`default_nettype none
module tmc_ext_src (
   // Clock
   input wire logic clk,
   // Control from the bench
   input wire logic [2:0] src_en,
   input wire logic [7:0] half_len,
   // Generated levels
   output logic [2:0] ext_out
);
   logic [7:0] cnt_reg = 8'h00;
   initial ext_out = 3'h0;
   // Enabled lines toggle every half_len cycles; a disabled source rests low
   always @(posedge clk) begin
      if (src_en == 3'h0) begin
         cnt_reg <= 8'h00;
         ext_out <= 3'h0;
      end else if (cnt_reg == half_len - 8'h01) begin
         cnt_reg <= 8'h00;
         ext_out <= ~ext_out & src_en;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule : tmc_ext_src
`default_nettype wire

// ==== test/tb_tmc_timers.sv ====
// Self-checking bench for the timer module framework
`timescale 1ns/100ps
`default_nettype none
`include "tmc_cfg.svh"
module tb_tmc_timers
   import tmc_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] ext, irq_a, irq_p;
   logic [2:0] src_en = 3'h0;
   logic pa0, pa1, pb0, pb1, ps0, p0, rd_d;
   logic [4:0] oe_n;
   logic [7:0] exp_q[$];
   int divs[5] = '{`TMC_DIV_SYS4, 1, `TMC_DIV_H16, `TMC_DIV_H64, `TMC_TBC_DIV};
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   int t0, t1, av;
   // Timer under test as a register base, and whether to wait for the P event
   logic [3:0] tsel = 4'h0;
   bit wait_p = 1'b0;
   // 250 MHz clock and a free cycle count for interval checks
   initial forever #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   tmc_timers DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_timer_input(ext),
      .irq_cmp_a(irq_a), .irq_cmp_p(irq_p), .timer_a_out_primary(pa0),
      .timer_a_out_secondary(pa1), .timer_b_out_primary(pb0), .timer_b_out_secondary(pb1),
      .standard_out_primary(ps0), .timer_pin_oe_n(oe_n));
   tmc_ext_src SRC (.clk(clk), .src_en(src_en), .half_len(8'h14), .ext_out(ext));
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: read 0x%h expected 0x%h", $time, got, exp);
      end
   endtask : cmp_rd
   task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got 0x%h expected 0x%h", $time, got, exp);
      end
   endtask : cmp_val
   // Read data stand only in the cycle after the strobe: take the oldest note
   always @(posedge clk) rd_d <= reg_rd;
   always @(negedge clk) begin
      if (rd_d === 1'b1) begin
         cmp_rd(reg_rdata, exp_q.pop_front());
      end
   end
   // Bus cycles end with an idle edge so a strobe is never set twice at once
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : rd
   // Stop, configure and restart the timer at base tsel; the run rise clears its counter
   task automatic prog(input logic [2:0] ck, input logic [7:0] c1, input logic [7:0] a);
      wr(tsel + `TMC_REG_CTRL0_A, 8'h00);
      wr(tsel + `TMC_REG_CTRL1_A, c1);
      wr(tsel + `TMC_REG_CMPA_A, a);
      wr(tsel + `TMC_REG_CNT_A, 8'h00);
      wr(tsel + `TMC_REG_CTRL0_A, {1'b0, ck, 1'b1, 3'h0});
   endtask : prog
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      while ((wait_p ? irq_p[tsel[3:2]] : irq_a[tsel[3:2]]) !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 3000) begin
         err_total++;
         give_verdict();
      end else begin
         t = cyc;
         @(posedge clk);
      end
   endtask : wait_irq
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hcaff_f266));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      // Defaults after reset; unmapped index reads zero
      rd(`TMC_REG_PINCTL, `TMC_PINCTL_RST);
      rd(`TMC_REG_LATCH, `TMC_LATCH_RST);
      rd(4'hF, 8'h00);
      cmp_val(16'(oe_n), 16'h001A);
      // Each internal clock code: match period is compare value times divider
      foreach (divs[k]) begin
         av = 2 + ($urandom % 4);
         prog(3'(k), 8'hC1, 8'(av));
         wait_irq(t0);
         wait_irq(t1);
         cmp_val(16'(t1 - t0), 16'(av * divs[k]));
      end
      // Only comparator A matched; status clears on read
      wr(`TMC_REG_CTRL0_A, 8'h00);
      rd(`TMC_REG_STATUS, 8'h01);
      rd(`TMC_REG_STATUS, 8'h00);
      // Reserved code leaves the counter without a clock
      prog(TMC_CK_NONE, 8'hC1, 8'hFF);
      repeat (300) @(posedge clk);
      rd(`TMC_REG_CNT_A, 8'h00);
      rd(`TMC_REG_CMPA_A, 8'h00);
      rd(`TMC_REG_STATUS, 8'h00);
      // External input: the second active edge reaches compare value 2
      for (int e = 0; e < 2; e++) begin
         src_en <= 3'h0;
         repeat (10) @(posedge clk);
         prog(e ? TMC_CK_EXT_FALL : TMC_CK_EXT_RISE, 8'hC1, 8'h02);
         src_en <= 3'h1;
         t0 = cyc;
         wait_irq(t1);
         cmp_val(16'(t1 - t0 >= 60 + 20 * e && t1 - t0 <= 75 + 20 * e), 16'h0001);
      end
      src_en <= 3'h0;
      // Compare output low, high, toggle; second pin inverted by its latch bit
      wr(`TMC_REG_PINCTL, 8'h03);
      wr(`TMC_REG_LATCH, 8'h02);
      for (int io = 1; io < 4; io++) begin
         prog(TMC_CK_SYS, {2'b00, 2'(io), io == 1, 3'b001}, 8'h04);
         wait_irq(t0);
         if (io < 3) begin
            cmp_val(16'(pa0), 16'(io - 1));
         end else begin
            p0 = pa0;
            wait_irq(t1);
            cmp_val(16'(pa0), 16'(!p0));
         end
         cmp_val(16'(pa1), 16'(!pa0));
         cmp_val(16'(oe_n), 16'h001C);
      end
      // Edge aligned PWM: period from P code 1 (128 counts), duty from A (32 counts)
      prog(TMC_CK_SYS, 8'h80, 8'h20);
      wr(`TMC_REG_CTRL0_A, 8'h19);
      wait_p = 1'b1;
      wait_irq(t0);
      wait_irq(t1);
      wait_p = 1'b0;
      cmp_val(16'(t1 - t0), 16'h0080);
      av = 0;
      repeat (128) begin
         @(posedge clk);
         av += pa0;
      end
      cmp_val(16'(av), 16'h0020);
      // Compact timer b drives a complementary pair; the standard timer a single pulse
      wr(`TMC_REG_PINCTL, 8'h1C);
      wr(`TMC_REG_LATCH, 8'h08);
      tsel = 4'h4;
      prog(TMC_CK_SYS, 8'h21, 8'h04);
      wait_irq(t0);
      cmp_val(16'({pb0, pb1}), 16'h0002);
      tsel = 4'h8;
      prog(TMC_CK_SYS, 8'h41, 8'h10);
      av = 0;
      t1 = 0;
      repeat (60) begin
         @(posedge clk);
         av += ps0;
         t1 += irq_a[2];
      end
      tsel = 4'h0;
      cmp_val(16'(av), 16'h0010);
      cmp_val(16'(t1), 16'h0003);
      // Pins handed back to their other function go quiet
      wr(`TMC_REG_PINCTL, 8'h00);
      @(posedge clk);
      cmp_val(16'({oe_n, pa0, pa1}), 16'h007C);
      give_verdict();
   end
endmodule : tb_tmc_timers
bind tmc_timers tmc_monitor MON (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .irq_cmp_a, .irq_cmp_p, .timer_a_out_primary, .timer_a_out_secondary,
   .standard_out_primary, .timer_pin_oe_n);
`default_nettype wire
